/* pkg/iso_rx_pkg.sv */
// package: register map, field positions, reset values and states of the receive context filter
package iso_rx_pkg;
	localparam int CTX_COUNT = 4;
	localparam int CTX_IDX_W = 2;
	localparam int ADDR_W = 16;

	// register map, byte addresses; per-context registers repeat at CTX_STRIDE
	localparam logic [15:0] CTRL_BASE = 16'h0400;
	localparam logic [15:0] STAGE_BASE = 16'h0408;
	localparam logic [15:0] PTR_BASE = 16'h040C;
	localparam logic [15:0] MATCH_BASE = 16'h410C;
	localparam logic [15:0] CTX_STRIDE = 16'h0020;
	localparam logic [15:0] MASK_HI_OFF = 16'h0070;
	localparam logic [15:0] MASK_LO_OFF = 16'h0078;

	// match register fields
	localparam int TAG11_BIT = 31;
	localparam int TAG10_BIT = 30;
	localparam int TAG01_BIT = 29;
	localparam int TAG00_BIT = 28;
	localparam int START_CYC_MSB = 26;
	localparam int START_CYC_LSB = 12;
	localparam int SYNC_MSB = 11;
	localparam int SYNC_LSB = 8;
	localparam int SYNC_FILT_BIT = 6;
	localparam int CHAN_MSB = 5;
	localparam logic [31:0] MATCH_WMASK = 32'hF7FF_FF7F;
	localparam logic [31:0] MATCH_RESET = 32'h0000_0000;

	// context control fields
	localparam int CYC_EN_BIT = 29;
	localparam int MASK_MODE_BIT = 28;
	localparam int RUN_BIT = 15;
	localparam int ACTIVE_BIT = 10;

	localparam logic [31:0] PTR_RESET = 32'h0000_0000;
	localparam logic [63:0] CHAN_MASK_RESET = 64'h0000_0000_0000_0000;

	localparam logic [1:0] WAIT_SYNC_CODE = 2'h3;
	localparam logic [1:0] TAG_01 = 2'h1;
	localparam logic [1:0] SYNC_UPPER_OK = 2'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CTX_IDLE = 2'b00,
		CTX_WAIT_CYCLE = 2'b01,
		CTX_WAIT_SYNC = 2'b10,
		CTX_RECEIVE = 2'b11
	} ctx_state_t;
endpackage

/* pkg/regbus_if.sv */
// interface: internal register access between the bus slave and the register file
`timescale 1ns/1ps
interface regbus_if;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic rd_en;
	logic [15:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_hit;
	modport bus_side (
		output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_hit, rd_data, rd_hit
	);
	modport reg_side (
		input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_hit, rd_data, rd_hit
	);
endinterface

/* hdl/ctx_filter.sv */
// module: tag, sync and channel acceptance test of one receive context
`timescale 1ns/1ps
module ctx_filter
	import iso_rx_pkg::*;
(
	input wire logic [31:0] match_word,
	input wire logic mask_mode,
	input wire logic [63:0] chan_mask,
	input wire logic [5:0] pkt_channel,
	input wire logic [1:0] pkt_tag,
	input wire logic [3:0] pkt_sync,
	output logic hit
);
	logic tag_ok;
	logic chan_ok;

	// tag enables decide alone, except the filtered tag-01b case
	always_comb begin
		unique case (pkt_tag)
			2'h3: tag_ok = match_word[TAG11_BIT];
			2'h2: tag_ok = match_word[TAG10_BIT];
			// upper sync bits gate tag 01b
			TAG_01: tag_ok = match_word[TAG01_BIT] &&
				(!match_word[SYNC_FILT_BIT] || pkt_sync[3:2] == SYNC_UPPER_OK);
			default: tag_ok = match_word[TAG00_BIT];
		endcase
	end

	always_comb begin
		if (mask_mode) begin
			chan_ok = chan_mask[pkt_channel];
		end else begin
			chan_ok = (pkt_channel == match_word[CHAN_MSB:0]);
		end
	end

	assign hit = tag_ok && chan_ok;
endmodule

/* hdl/axil_regbus_slave.sv */
// module: AXI4-Lite slave that turns bus transfers into single-cycle register accesses
`timescale 1ns/1ps
module axil_regbus_slave
	import iso_rx_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	regbus_if.bus_side rb
);
	typedef struct packed {
		logic awready;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic wready;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} slave_state_t;

	localparam slave_state_t SLAVE_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
		default: '0};

	slave_state_t st;
	slave_state_t next_st;

	// register access strobes; the write happens once both halves are held
	assign rb.wr_en = st.aw_held && st.w_held && !st.bvalid;
	assign rb.wr_addr = st.aw_addr;
	assign rb.wr_data = st.wdata;
	assign rb.wr_strb = st.wstrb;
	assign rb.rd_en = s_axi_arvalid && st.arready;
	assign rb.rd_addr = s_axi_araddr;

	// address and data are taken in either order; ready drops until the response is taken
	always_comb begin
		next_st = st;
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			next_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
			next_st.wready = 1'b0;
		end
		if (rb.wr_en) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end
		// read data is captured at acceptance, so it never changes while rvalid waits
		if (rb.rd_en) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rdata = rb.rd_data;
			next_st.rresp = rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= SLAVE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
endmodule

/* hdl/iso_rx_context_match_filter.sv */
// module: isochronous receive context start, match registers and packet acceptance
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module iso_rx_context_match_filter
	import iso_rx_pkg::*;
#(
	parameter int NUM_CTX = CTX_COUNT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pkt_valid,
	input wire logic [5:0] pkt_channel,
	input wire logic [1:0] pkt_tag,
	input wire logic [3:0] pkt_sync,
	input wire logic [6:0] timer_seconds_count,
	input wire logic [12:0] timer_cycle_number,
	input wire logic [2*NUM_CTX-1:0] desc_wait_field,
	output logic [NUM_CTX-1:0] pkt_accept,
	output logic fetch_valid,
	output logic [CTX_IDX_W-1:0] fetch_context,
	output logic [31:0] fetch_address
);
	typedef struct packed {
		logic [NUM_CTX-1:0][31:0] match;
		logic [NUM_CTX-1:0][31:0] staging;
		logic [NUM_CTX-1:0][31:0] pointer;
		logic [NUM_CTX-1:0] run;
		logic [NUM_CTX-1:0] start_on_cycle_enable;
		logic [NUM_CTX-1:0] mask_based_channel_select;
		logic [63:0] chan_mask;
		ctx_state_t [NUM_CTX-1:0] state;
		logic [NUM_CTX-1:0] accept;
		logic fetch_valid;
		logic [CTX_IDX_W-1:0] fetch_context;
		logic [31:0] fetch_address;
	} filt_state_t;

	filt_state_t st;
	filt_state_t next_st;
	logic [NUM_CTX-1:0] chan_hit;

	regbus_if rb ();

	axil_regbus_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rb(rb.bus_side)
	);

	// one acceptance test per context; the state machine below decides timing
	for (genvar g = 0; g < NUM_CTX; g++) begin : g_filter
		ctx_filter u_filter (
			.match_word(st.match[g]),
			.mask_mode(st.mask_based_channel_select[g]),
			.chan_mask(st.chan_mask),
			.pkt_channel(pkt_channel),
			.pkt_tag(pkt_tag),
			.pkt_sync(pkt_sync),
			.hit(chan_hit[g])
		);
	end

	// merge write data into an old value under byte strobes and a writable-bit mask
	function automatic logic [31:0] merge_write(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb,
		input logic [31:0] wmask
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return res & wmask;
	endfunction

	// control word as software sees it; active shows that the context left idle
	function automatic logic [31:0] ctrl_word(
		input logic run,
		input logic cyc_en,
		input logic mask_sel,
		input ctx_state_t cs
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[RUN_BIT] = run;
		w[CYC_EN_BIT] = cyc_en;
		w[MASK_MODE_BIT] = mask_sel;
		w[ACTIVE_BIT] = (cs != CTX_IDLE);
		return w;
	endfunction

	localparam logic [31:0] CTRL_WMASK = 32'h3000_8000;

	always_comb begin
		logic [15:0] ofs;
		logic [31:0] cw;
		logic sync_wait;
		logic sync_ok;
		logic [14:0] cycle_now;
		ofs = 16'h0000;
		cw = 32'h0000_0000;
		sync_wait = 1'b0;
		sync_ok = 1'b0;
		// seconds low bits joined with cycle count
		cycle_now = {timer_seconds_count[1:0], timer_cycle_number};
		next_st = st;
		next_st.accept = '0;
		next_st.fetch_valid = 1'b0;
		rb.rd_data = 32'h0000_0000;
		rb.rd_hit = 1'b0;
		rb.wr_hit = 1'b0;

		// shared channel mask, high word holds channels 63..32
		if (rb.rd_addr == MASK_HI_OFF) begin
			rb.rd_hit = 1'b1;
			rb.rd_data = st.chan_mask[63:32];
		end
		if (rb.rd_addr == MASK_LO_OFF) begin
			rb.rd_hit = 1'b1;
			rb.rd_data = st.chan_mask[31:0];
		end
		if (rb.wr_addr == MASK_HI_OFF) begin
			rb.wr_hit = 1'b1;
			if (rb.wr_en) begin
				next_st.chan_mask[63:32] = merge_write(st.chan_mask[63:32], rb.wr_data,
					rb.wr_strb, 32'hFFFF_FFFF);
			end
		end
		if (rb.wr_addr == MASK_LO_OFF) begin
			rb.wr_hit = 1'b1;
			if (rb.wr_en) begin
				next_st.chan_mask[31:0] = merge_write(st.chan_mask[31:0], rb.wr_data,
					rb.wr_strb, 32'hFFFF_FFFF);
			end
		end

		for (int n = 0; n < NUM_CTX; n++) begin
			// per-context copies at a fixed stride
			ofs = CTX_STRIDE * 16'(n);
			cw = ctrl_word(st.run[n], st.start_on_cycle_enable[n],
				st.mask_based_channel_select[n], st.state[n]);

			// register reads
			if (rb.rd_addr == CTRL_BASE + ofs) begin
				rb.rd_hit = 1'b1;
				rb.rd_data = cw;
			end
			if (rb.rd_addr == STAGE_BASE + ofs) begin
				rb.rd_hit = 1'b1;
				rb.rd_data = st.staging[n];
			end
			if (rb.rd_addr == PTR_BASE + ofs) begin
				rb.rd_hit = 1'b1;
				rb.rd_data = st.pointer[n];
			end
			if (rb.rd_addr == MATCH_BASE + ofs) begin
				rb.rd_hit = 1'b1;
				rb.rd_data = st.match[n];
			end

			// register writes; the pointer itself is read-only and a write is a no-op
			if (rb.wr_addr == PTR_BASE + ofs) begin
				rb.wr_hit = 1'b1;
			end
			if (rb.wr_addr == STAGE_BASE + ofs) begin
				rb.wr_hit = 1'b1;
				if (rb.wr_en) begin
					next_st.staging[n] = merge_write(st.staging[n], rb.wr_data, rb.wr_strb,
						32'hFFFF_FFFF);
				end
			end
			if (rb.wr_addr == MATCH_BASE + ofs) begin
				rb.wr_hit = 1'b1;
				if (rb.wr_en) begin
					next_st.match[n] = merge_write(st.match[n], rb.wr_data, rb.wr_strb,
						MATCH_WMASK);
				end
			end
			if (rb.wr_addr == CTRL_BASE + ofs) begin
				rb.wr_hit = 1'b1;
				if (rb.wr_en) begin
					cw = merge_write(cw, rb.wr_data, rb.wr_strb, CTRL_WMASK);
					next_st.run[n] = cw[RUN_BIT];
					next_st.start_on_cycle_enable[n] = cw[CYC_EN_BIT];
					next_st.mask_based_channel_select[n] = cw[MASK_MODE_BIT];
				end
			end

			if (!st.run[n] && next_st.run[n]) begin
				next_st.pointer[n] = st.staging[n];
				next_st.fetch_valid = 1'b1;
				next_st.fetch_context = CTX_IDX_W'(n);
				next_st.fetch_address = st.staging[n];
			end

			// wait code 11b enables sync compare
			sync_wait = (desc_wait_field[2*n +: 2] == WAIT_SYNC_CODE);
			sync_ok = (pkt_sync == st.match[n][SYNC_MSB:SYNC_LSB]);

			// reception sequence of one context
			unique case (st.state[n])
				CTX_IDLE: begin
					if (st.run[n]) begin
						if (st.start_on_cycle_enable[n]) begin
							next_st.state[n] = CTX_WAIT_CYCLE;
						end else if (sync_wait) begin
							next_st.state[n] = CTX_WAIT_SYNC;
						end else begin
							next_st.state[n] = CTX_RECEIVE;
						end
					end
				end
				CTX_WAIT_CYCLE: begin
					// hold off until the cycle matches
					if (cycle_now == st.match[n][START_CYC_MSB:START_CYC_LSB]) begin
						next_st.state[n] = sync_wait ? CTX_WAIT_SYNC : CTX_RECEIVE;
					end
				end
				CTX_WAIT_SYNC: begin
					if (!sync_wait) begin
						next_st.state[n] = CTX_RECEIVE;
					end else if (pkt_valid && chan_hit[n] && sync_ok) begin
						next_st.accept[n] = 1'b1;
						next_st.state[n] = CTX_RECEIVE;
					end
				end
				CTX_RECEIVE: begin
					next_st.accept[n] = pkt_valid && chan_hit[n];
				end
			endcase

			// stopping a context drops it back to idle whatever it was doing
			if (!st.run[n]) begin
				next_st.state[n] = CTX_IDLE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pkt_accept = st.accept;
	assign fetch_valid = st.fetch_valid;
	assign fetch_context = st.fetch_context;
	assign fetch_address = st.fetch_address;
endmodule

/* dv/iso_rx_context_match_filter_properties.sv */
// checker: write, start and packet acceptance properties of the receive context filter
`timescale 1ns/1ps
module iso_rx_checker
	import iso_rx_pkg::*;
#(
	parameter int NUM_CTX = CTX_COUNT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic pkt_valid,
	input wire logic [5:0] pkt_channel,
	input wire logic [1:0] pkt_tag,
	input wire logic [3:0] pkt_sync,
	input wire logic [NUM_CTX-1:0] pkt_accept,
	input wire logic fetch_valid
);
	logic [ADDR_W-1:0] aw_q;
	logic [31:0] w_q, m0, c0;
	logic aw_f, w_f;
	// context 0 shadows; full strobes assumed, update lands on the edge that raises bvalid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_f, w_f, m0, c0} <= '0;
		end else if (aw_f && w_f) begin
			{aw_f, w_f} <= 2'h0;
			if (aw_q == MATCH_BASE) m0 <= w_q & MATCH_WMASK;
			if (aw_q == CTRL_BASE) c0 <= w_q;
		end else begin
			if (s_axi_awvalid && s_axi_awready) {aw_f, aw_q} <= {1'b1, s_axi_awaddr};
			if (s_axi_wvalid && s_axi_wready) {w_f, w_q} <= {1'b1, s_axi_wdata};
		end
	end
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	tag_enable_gate_a: assert property (
		pkt_valid && !m0[TAG00_BIT + pkt_tag] |=> !pkt_accept[0]) else $error("tag disabled");
	channel_gate_a: assert property (
		pkt_valid && !c0[MASK_MODE_BIT] && pkt_channel != m0[CHAN_MSB:0] |=> !pkt_accept[0])
		else $error("wrong channel accepted");
	sync_filter_a: assert property (
		pkt_valid && pkt_tag == TAG_01 && m0[SYNC_FILT_BIT] && pkt_sync[3:2] != SYNC_UPPER_OK
		|=> !pkt_accept[0]) else $error("sync filter ignored");
	stopped_silent_a: assert property (
		pkt_valid && !c0[RUN_BIT] && !$past(c0[RUN_BIT]) |=> !pkt_accept[0])
		else $error("accept while stopped");
	accept_cause_a: assert property (|pkt_accept |-> $past(pkt_valid))
		else $error("accept without packet");
	fetch_on_write_a: assert property (fetch_valid |-> $rose(s_axi_bvalid))
		else $error("fetch not at write");
	fetch_single_a: assert property (fetch_valid |=> !fetch_valid [*2])
		else $error("fetch repeated");
	write_lockout_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	cover property (fetch_valid);
	cover property (pkt_accept[0]);
	cover property (pkt_valid && pkt_tag == TAG_01 ##1 pkt_accept[1]);
endmodule

bind iso_rx_context_match_filter iso_rx_checker #(.NUM_CTX(NUM_CTX)) u_iso_rx_checker (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .pkt_valid, .pkt_channel, .pkt_tag,
	.pkt_sync, .pkt_accept, .fetch_valid
);

/* dv/link_pkt_source.sv */
// model: link layer presenting packet headers and running the cycle timer
`timescale 1ns/1ps
module link_pkt_source (
	input wire logic aclk,
	output logic pkt_valid,
	output logic [5:0] pkt_channel,
	output logic [1:0] pkt_tag,
	output logic [3:0] pkt_sync,
	output logic [6:0] timer_seconds_count,
	output logic [12:0] timer_cycle_number
);
	bit busy;
	initial begin
		{pkt_valid, pkt_channel, pkt_tag, pkt_sync} = '0;
		{timer_seconds_count, timer_cycle_number} = '0;
	end
	// timer advances one bus cycle per clock to keep runs short
	always @(posedge aclk) begin
		if (timer_cycle_number == 13'h1F3F) begin
			timer_cycle_number <= 13'h0000;
			timer_seconds_count <= timer_seconds_count + 7'h01;
		end else begin
			timer_cycle_number <= timer_cycle_number + 13'h0001;
		end
		// header lines mean nothing between packets, so keep them moving
		if (!pkt_valid && !busy) {pkt_channel, pkt_tag, pkt_sync} <= ~{pkt_channel, pkt_tag, pkt_sync};
	end
	task send(input logic [5:0] ch, input logic [1:0] tg, input logic [3:0] sy);
		busy = 1'b1;
		@(posedge aclk);
		pkt_valid <= 1'b1;
		{pkt_channel, pkt_tag, pkt_sync} <= {ch, tg, sy};
		@(posedge aclk);
		pkt_valid <= 1'b0;
		busy = 1'b0;
	endtask
endmodule

/* dv/test_iso_rx_context_match_filter.sv */
// testbench: registers, context start, cycle and sync waits, packet filter vs model
`timescale 1ns/1ps
module test_iso_rx_context_match_filter
	import iso_rx_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pkt_valid;
	logic fetch_valid;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, fetch_address, seed, stage;
	logic [3:0] s_axi_wstrb, pkt_sync, pkt_accept;
	logic [1:0] s_axi_bresp, s_axi_rresp, pkt_tag, fetch_context;
	logic [5:0] pkt_channel;
	logic [6:0] timer_seconds_count;
	logic [12:0] timer_cycle_number;
	logic [7:0] desc_wait_field;
	logic [63:0] mask;
	int fails, n_compared, fetches, target, m[4], c[4];
	bit rn[4], ws[4], wc[4];
	iso_rx_context_match_filter u_iso_rx_context_match_filter (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pkt_valid, .pkt_channel,
		.pkt_tag, .pkt_sync, .timer_seconds_count, .timer_cycle_number, .desc_wait_field,
		.pkt_accept, .fetch_valid, .fetch_context, .fetch_address);
	link_pkt_source u_link_pkt_source (.aclk, .pkt_valid, .pkt_channel, .pkt_tag, .pkt_sync,
		.timer_seconds_count, .timer_cycle_number);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// watchdog: the sequence needs under fifteen hundred cycles
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		end_of_test();
	end
	// count fetch pulses mid-cycle, so the count is settled when a write task returns
	always @(negedge aclk) begin
		if (fetch_valid === 1'b1) fetches++;
	end
	function logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function logic [15:0] reg_at(logic [15:0] base, int n);
		return base + CTX_STRIDE * 16'(n);
	endfunction
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'(er));
	endtask
	task rdchk(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, ed);
		chk("rresp", 32'(s_axi_rresp), 32'(er));
	endtask
	function automatic bit want(int n, logic [5:0] ch, logic [1:0] tg, logic [3:0] sy);
		bit ok;
		ok = rn[n] && !wc[n] && m[n][28 + tg];
		// filter bites only on tag 01
		if (tg == TAG_01 && m[n][6] && sy[3:2] != 2'h0) ok = 1'b0;
		// channel field, or the shared mask in mask mode
		if (c[n][28] ? !mask[ch] : m[n][5:0] != ch) ok = 1'b0;
		// discard until the programmed sync arrives
		if (ok && ws[n]) begin
			ok = (sy == m[n][11:8]);
			ws[n] = !ok;
		end
		return ok;
	endfunction
	task pkt(input logic [5:0] ch, input logic [1:0] tg, input logic [3:0] sy);
		logic [3:0] e;
		for (int n = 0; n < 4; n++) e[n] = want(n, ch, tg, sy);
		u_link_pkt_source.send(ch, tg, sy);
		#1;
		chk("pkt_accept", 32'(pkt_accept), 32'(e));
	endtask
	initial begin
		seed = 32'h0001_50BC;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		desc_wait_field = 8'h00;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// cleared contexts; reserved bits and pointer refuse writes
		for (int n = 0; n < 4; n++) begin
			rdchk(reg_at(MATCH_BASE, n), MATCH_RESET, RESP_OKAY);
			wr(reg_at(MATCH_BASE, n), 32'hFFFF_FFFF, RESP_OKAY);
			rdchk(reg_at(MATCH_BASE, n), MATCH_WMASK, RESP_OKAY);
			wr(reg_at(PTR_BASE, n), 32'hFFFF_FFFF, RESP_OKAY);
			rdchk(reg_at(PTR_BASE, n), PTR_RESET, RESP_OKAY);
		end
		wr(16'h0200, 32'h1234_5678, RESP_SLVERR);
		rdchk(16'h0200, 32'h0000_0000, RESP_SLVERR);
		// byte strobes: only the low lane of context 2 match is cleared
		s_axi_wstrb <= 4'h1;
		wr(reg_at(MATCH_BASE, 2), 32'h0000_0000, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdchk(reg_at(MATCH_BASE, 2), MATCH_WMASK & 32'hFFFF_FF00, RESP_OKAY);
		mask = {rnd(), rnd()};
		wr(MASK_HI_OFF, mask[63:32], RESP_OKAY);
		wr(MASK_LO_OFF, mask[31:0], RESP_OKAY);
		desc_wait_field <= {4'h0, WAIT_SYNC_CODE, 2'h0};
		ws[1] = 1'b1;
		// start field: seconds[1:0] joined with cycle, a few hundred cycles ahead
		target = timer_seconds_count * 8000 + timer_cycle_number + 400;
		for (int n = 0; n < 4; n++) begin
			m[n] = (rnd() & 32'hF000_0F40) | n;
			if (n == 0) m[0] = m[0] | ((target / 8000 % 4) * 8192 + target % 8000) << 12;
			c[n] = {2'h0, n == 0, n == 3, 12'h000, 1'b1, 15'h0000};
			stage = rnd();
			wr(reg_at(MATCH_BASE, n), m[n], RESP_OKAY);
			wr(reg_at(STAGE_BASE, n), stage, RESP_OKAY);
			wr(reg_at(CTRL_BASE, n), c[n], RESP_OKAY);
			chk("fetches", 32'(fetches), 32'(n + 1));
			chk("fetch_context", 32'(fetch_context), 32'(n));
			chk("fetch_address", fetch_address, stage);
			rdchk(reg_at(PTR_BASE, n), stage, RESP_OKAY);
			rdchk(reg_at(CTRL_BASE, n), c[n] | 32'h0000_0400, RESP_OKAY);
			rn[n] = 1'b1;
			wc[n] = (n == 0);
		end
		wr(reg_at(CTRL_BASE, 2), c[2], RESP_OKAY);
		chk("fetches", 32'(fetches), 32'h0000_0004);
		for (int t = 0; t < 4; t++) pkt(6'h00, 2'(t), 4'h0);
		while (timer_seconds_count * 8000 + timer_cycle_number < target + 3) @(posedge aclk);
		wc[0] = 1'b0;
		repeat (400) begin
			stage = rnd();
			pkt({3'h0, stage[2:0]}, stage[5:4], stage[11:8]);
		end
		for (int n = 0; n < 4; n++) begin
			wr(reg_at(CTRL_BASE, n), 32'h0000_0000, RESP_OKAY);
			rn[n] = 1'b0;
		end
		repeat (20) begin
			stage = rnd();
			pkt({3'h0, stage[2:0]}, stage[5:4], stage[11:8]);
		end
		end_of_test();
	end
endmodule
